// *** core/bonded_rx_clock_distribution.v ***
// Bonded receive clock distribution and shared phase compensation datapath.
`timescale 1ns/1ps
`include "rx_bond_consts.vh"
module bonded_rx_clock_distribution #(
  parameter LANES  = 8,
  parameter LS_DIV = `LS_DIV_DEFAULT
) (
  input  wire                  clk_sys_i,
  input  wire                  reset_n_i,
  input  wire [2:0]            mode_i,
  input  wire                  gen2_i,
  input  wire                  byte_deser_en_i,
  input  wire                  hard_core_en_i,
  input  wire                  slave_block_ok_i,
  input  wire [LANES-1:0]      lane_ser_toggle_i,
  input  wire [2*LANES-1:0]    lane_ser_bits_i,
  input  wire                  fabric_ready_i,
  output reg                   fabric_clk_en_o,
  output wire                  fabric_valid_o,
  output wire [16*LANES-1:0]   fabric_data_o,
  output reg  [7:0]            active_lanes_o,
  output reg                   deskew_active_o,
  output reg                   config_err_o,
  output reg                   code_err_o,
  output reg                   overflow_o,
  output reg  [17:0]           fabric_khz_o
);
  localparam PW = 16 * LANES;
  localparam AW = `PCOMP_DEPTH_LOG2;
  localparam DEPTH = 1 << AW;

  // ------------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------------
  reg        deskew_d;
  reg [7:0]  lanes_d;
  reg        err_d;
  reg [17:0] khz_d;
  wire       pcie = (mode_i == `MODE_PCIE_X4) || (mode_i == `MODE_PCIE_X8);

  // Generic modes report no fabric rate, since their line rate is the user's.
  always @* begin
    deskew_d = 1'b0;
    lanes_d  = `LANES_BLOCK;
    err_d    = 1'b0;
    khz_d    = `KHZ_UNSPEC;
    case (mode_i)
      `MODE_PCIE_X4: lanes_d = `LANES_BLOCK;
      `MODE_XAUI: begin
        deskew_d = 1'b1;
        lanes_d  = `LANES_BLOCK;
      end
      `MODE_GENERIC_X4: lanes_d = `LANES_BLOCK;
      `MODE_PCIE_X8: begin
        lanes_d = `LANES_BONDED_X8;
        err_d   = ~slave_block_ok_i;
      end
      `MODE_GENERIC_X8: begin
        lanes_d = `LANES_BONDED_X8;
        err_d   = ~slave_block_ok_i;
      end
      default: err_d = 1'b1;
    endcase
    if (mode_i == `MODE_XAUI) begin
      khz_d = `KHZ_XAUI_FABRIC;
      if (!byte_deser_en_i) begin
        err_d = 1'b1;
      end
    end
    if (pcie) begin
      if (gen2_i) begin
        khz_d = `KHZ_GEN2_BD;
        if (!byte_deser_en_i) begin
          err_d = 1'b1;
        end
      end else if (byte_deser_en_i) begin
        khz_d = `KHZ_GEN1_BD;
      // no byte deserializer needs hard core
      end else if (hard_core_en_i) begin
        khz_d = `KHZ_GEN1_NOBD_HARD;
      end else begin
        err_d = 1'b1;
      end
    end
    if (lanes_d > LANES) begin
      err_d = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  // The toggle takes a third stage so that its edge is seen on settled bits;
  // the lane bits take two and line up with the second toggle stage.
  reg [LANES-1:0]   tog_s1_q;
  reg [LANES-1:0]   tog_s2_q;
  reg [LANES-1:0]   tog_s3_q;
  reg [2*LANES-1:0] bits_s1_q;
  reg [2*LANES-1:0] bits_s2_q;

  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      tog_s1_q  <= {LANES{1'b0}};
      tog_s2_q  <= {LANES{1'b0}};
      tog_s3_q  <= {LANES{1'b0}};
      bits_s1_q <= {2*LANES{1'b0}};
      bits_s2_q <= {2*LANES{1'b0}};
    end else begin
      tog_s1_q  <= lane_ser_toggle_i;
      tog_s2_q  <= tog_s1_q;
      tog_s3_q  <= tog_s2_q;
      bits_s1_q <= lane_ser_bits_i;
      bits_s2_q <= bits_s1_q;
    end
  end

  // ------------------------------------------------------------------
  // Low-speed divider of the first clock management unit
  // ------------------------------------------------------------------
  // One divider serves every lane, so the slave block's divider never
  // steers timing and the lanes cannot drift apart on the read side.
  reg [7:0] ls_cnt_q;
  reg       ls_tick_q;
  reg       half_q;
  // A bad configuration parks the divider so that no fabric enable escapes.
  wire      ls_run = ~config_err_o;

  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      ls_cnt_q  <= 8'h00;
      ls_tick_q <= 1'b0;
      half_q    <= 1'b0;
    end else if (ls_run) begin
      ls_tick_q <= (ls_cnt_q == LS_DIV[7:0] - 8'h01);
      ls_cnt_q  <= (ls_cnt_q == LS_DIV[7:0] - 8'h01) ? 8'h00 : ls_cnt_q + 8'h01;
      if (ls_tick_q) begin
        half_q <= ~half_q;
      end
    end else begin
      ls_tick_q <= 1'b0;
      ls_cnt_q  <= 8'h00;
      half_q    <= 1'b0;
    end
  end

  wire pcomp_tick = ls_tick_q & (~byte_deser_en_i | half_q);

  // ------------------------------------------------------------------
  // Per-lane recovery, alignment and rate match
  // ------------------------------------------------------------------
  wire [LANES-1:0] ser_tick = tog_s2_q ^ tog_s3_q;
  wire [LANES-1:0] par_tick;
  wire [LANES-1:0] lane_on;
  wire [LANES-1:0] rm_valid;
  wire [LANES-1:0] sym_bad;
  wire [PW-1:0]    lane_word;

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : lane
      reg [2:0]  ser_cnt_q;
      reg        par_q;
      reg [9:0]  shift_q;
      reg [9:0]  aligned_q;
      reg [9:0]  rm_q;
      reg        rm_v_q;
      reg [7:0]  dec_q;
      reg        al_v_q;
      reg [7:0]  low_q;
      reg [15:0] word_q;
      reg        bad_q;
      integer    k;
      reg [3:0]  ones;
      wire       rm_wr;

      assign lane_on[g]  = (g < active_lanes_o);
      assign par_tick[g] = par_q;
      assign rm_valid[g] = rm_v_q;
      assign sym_bad[g]  = bad_q;
      assign lane_word[16*g +: 16] = word_q;
      // Deskew mode writes every lane on lane 0's tick to line the group up.
      // lane 0 drives deskew write
      // own lane drives rate match write
      assign rm_wr = deskew_active_o ? par_tick[0] : par_q;

      always @* begin
        ones = 4'h0;
        for (k = 0; k < `SYM_W; k = k + 1) begin
          ones = ones + {3'h0, rm_q[k]};
        end
      end

      always @(posedge clk_sys_i) begin
        if (!reset_n_i || !lane_on[g]) begin
          ser_cnt_q <= 3'h0;
          par_q     <= 1'b0;
          shift_q   <= 10'h000;
          aligned_q <= 10'h000;
          rm_q      <= 10'h000;
          rm_v_q    <= 1'b0;
          dec_q     <= 8'h00;
          al_v_q    <= 1'b0;
          low_q     <= 8'h00;
          word_q    <= 16'h0000;
          bad_q     <= 1'b0;
        end else begin
          par_q <= 1'b0;
          if (ser_tick[g]) begin
            shift_q <= {shift_q[7:0], bits_s2_q[2*g +: 2]};
            if (ser_cnt_q == `SER_TICKS_PER_WORD - 3'h1) begin
              ser_cnt_q <= 3'h0;
              par_q     <= 1'b1;
            end else begin
              ser_cnt_q <= ser_cnt_q + 3'h1;
            end
          end
          // The first parallel tick finds no aligned word yet, so the rate match
          // slot is marked empty and the reset zeros it passes to the decoder raise no code error.
          // aligner on own clock
          if (par_q) begin
            aligned_q <= shift_q;
            al_v_q    <= 1'b1;
          end
          if (rm_wr) begin
            rm_q   <= aligned_q;
            rm_v_q <= al_v_q;
          end else if (ls_tick_q) begin
            rm_v_q <= 1'b0;
          end
          bad_q <= 1'b0;
          if (ls_tick_q) begin
            dec_q   <= rm_q[7:0];
            bad_q   <= rm_v_q & ((ones < 4'h4) | (ones > 4'h6));
            if (!half_q) begin
              low_q <= dec_q;
            end
          end
          if (pcomp_tick) begin
            word_q <= byte_deser_en_i ? {dec_q, low_q} : {8'h00, dec_q};
          end
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // Shared phase compensation FIFO
  // ------------------------------------------------------------------
  // One pointer pair for the whole group keeps every lane's word in the
  // same slot; a per-lane pointer could let one lane slip by a word.
  reg [PW-1:0] pcomp_mem [0:DEPTH-1];
  reg [AW:0]   wr_ptr_q;
  reg [AW:0]   rd_ptr_q;
  reg          started_q;
  wire         buf_ready;
  wire         pcomp_empty = (wr_ptr_q == rd_ptr_q);
  wire         pcomp_full  = (wr_ptr_q[AW] != rd_ptr_q[AW]) &&
                             (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  // Writes start only once lane 0 holds a word, so the group begins in step.
  wire         pcomp_wr    = pcomp_tick & started_q;
  wire         pcomp_rd    = ~pcomp_empty & buf_ready;

  always @(posedge clk_sys_i) begin
    if (!reset_n_i || config_err_o) begin
      wr_ptr_q  <= {AW+1{1'b0}};
      rd_ptr_q  <= {AW+1{1'b0}};
      started_q <= 1'b0;
    end else begin
      if (pcomp_tick && rm_valid[0]) begin
        started_q <= 1'b1;
      end
      if (pcomp_wr && !pcomp_full) begin
        wr_ptr_q <= wr_ptr_q + {{AW{1'b0}}, 1'b1};
      end
      if (pcomp_rd) begin
        rd_ptr_q <= rd_ptr_q + {{AW{1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge clk_sys_i) begin
    if (pcomp_wr && !pcomp_full) begin
      pcomp_mem[wr_ptr_q[AW-1:0]] <= lane_word;
    end
  end

  // The output buffer absorbs a fabric stall without losing a word; the
  // phase compensation FIFO behind it then fills and flags an overflow.
  rx_skid2 #(
    .W (PW)
  ) rx_skid2_i (
    .clk_sys_i   (clk_sys_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (pcomp_rd),
    .in_data_i   (pcomp_mem[rd_ptr_q[AW-1:0]]),
    .in_ready_o  (buf_ready),
    .out_valid_o (fabric_valid_o),
    .out_data_o  (fabric_data_o),
    .out_ready_i (fabric_ready_i)
  );

  // ------------------------------------------------------------------
  // Status and fabric clock enable
  // ------------------------------------------------------------------
  // Sticky flags clear only by reset, so a fault seen once stays visible.
  // shared fabric clock enable
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      fabric_clk_en_o <= 1'b0;
      active_lanes_o  <= `LANES_BLOCK;
      deskew_active_o <= 1'b0;
      config_err_o    <= 1'b0;
      code_err_o      <= 1'b0;
      overflow_o      <= 1'b0;
      fabric_khz_o    <= `KHZ_UNSPEC;
    end else begin
      fabric_clk_en_o <= pcomp_tick;
      active_lanes_o  <= lanes_d;
      deskew_active_o <= deskew_d;
      config_err_o    <= err_d;
      fabric_khz_o    <= err_d ? `KHZ_UNSPEC : khz_d;
      if (|sym_bad) begin
        code_err_o <= 1'b1;
      end
      if (pcomp_wr && pcomp_full) begin
        overflow_o <= 1'b1;
      end
    end
  end
endmodule

// *** core/rx_skid2.v ***
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module rx_skid2 #(
  parameter W = 16
) (
  input  wire         clk_sys_i,
  input  wire         reset_n_i,
  input  wire         in_valid_i,
  input  wire [W-1:0] in_data_i,
  output reg          in_ready_o,
  output reg          out_valid_o,
  output reg  [W-1:0] out_data_o,
  input  wire         out_ready_i
);
  reg [W-1:0] spare_q;
  reg         spare_v_q;
  wire        take = in_valid_i & in_ready_o;
  wire        give = out_valid_o & out_ready_i;

  // A stalled receiver parks the second word in the spare slot.
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= {W{1'b0}};
      spare_q     <= {W{1'b0}};
      spare_v_q   <= 1'b0;
      in_ready_o  <= 1'b0;
    end else begin
      if (!out_valid_o || give) begin
        if (spare_v_q) begin
          out_data_o  <= spare_q;
          out_valid_o <= 1'b1;
          spare_v_q   <= take;
          spare_q     <= in_data_i;
        end else begin
          out_data_o  <= in_data_i;
          out_valid_o <= take;
        end
        in_ready_o <= ~(spare_v_q & take);
      end else if (take) begin
        spare_q    <= in_data_i;
        spare_v_q  <= 1'b1;
        in_ready_o <= 1'b0;
      end else begin
        in_ready_o <= ~spare_v_q;
      end
    end
  end
endmodule

// *** shared/rx_bond_consts.vh ***
// Constants for the bonded receive clock distribution block.
`ifndef RX_BOND_CONSTS_VH
`define RX_BOND_CONSTS_VH

`define MODE_PCIE_X4       3'h0
`define MODE_XAUI          3'h1
`define MODE_GENERIC_X4    3'h2
`define MODE_PCIE_X8       3'h3
`define MODE_GENERIC_X8    3'h4

`define LANES_BLOCK        8'h04
`define LANES_BONDED_X8    8'h08

`define SER_BITS_PER_TICK  2
`define SER_TICKS_PER_WORD 3'h5
`define SYM_W              10
`define LS_DIV_DEFAULT     4
`define PCOMP_DEPTH_LOG2   2

`define KHZ_XAUI_FABRIC    18'h2625A
`define KHZ_GEN1_BD        18'h1E848
`define KHZ_GEN1_NOBD_HARD 18'h3D090
`define KHZ_GEN2_BD        18'h3D090
`define KHZ_UNSPEC         18'h00000

`endif

// *** verif/fabric_sink.sv ***
// Fabric-side model that accepts bonded lane words at a chosen pace.
`timescale 1ns/1ps
module fabric_sink (
  input  wire        clk_sys_i,
  input  wire        reset_n_i,
  input  wire        fabric_valid_i,
  input  wire [1:0]  pace_i,
  output reg         fabric_ready_o,
  output reg  [15:0] taken_o
);
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      fabric_ready_o <= 1'b0;
      taken_o        <= 16'h0000;
    end else begin
      // Pace 0 is prompt, 1 accepts every other cycle, 2 stalls outright.
      fabric_ready_o <= (pace_i == 2'h0) || (pace_i == 2'h1 && !fabric_ready_o);
      if (fabric_valid_i && fabric_ready_o) begin
        taken_o <= taken_o + 16'h0001;
      end
    end
  end
endmodule

// *** verif/rx_clock_dist_sva.sv ***
// Port checker for the bonded receive clock distribution block.
`timescale 1ns/1ps
`include "rx_bond_consts.vh"
module rx_clock_dist_sva #(
  parameter LANES = 8
) (
  input wire                clk_sys_i,
  input wire                reset_n_i,
  input wire [2:0]          mode_i,
  input wire                gen2_i,
  input wire                byte_deser_en_i,
  input wire                fabric_ready_i,
  input wire                fabric_clk_en_o,
  input wire                fabric_valid_o,
  input wire [16*LANES-1:0] fabric_data_o,
  input wire [7:0]          active_lanes_o,
  input wire                deskew_active_o,
  input wire                config_err_o,
  input wire                code_err_o,
  input wire                overflow_o,
  input wire [17:0]         fabric_khz_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // The gap check assumes the shortest divider of four cycles used on this bench.
  clk_gap_a: assert property (fabric_clk_en_o |=> !fabric_clk_en_o[*3])
    else $error("fabric clock enable pulses too close");
  err_stop_a: assert property (config_err_o[*3] |-> !fabric_clk_en_o)
    else $error("divider runs under a bad configuration");
  word_hold_a: assert property (fabric_valid_o && !fabric_ready_i |=>
    fabric_valid_o && $stable(fabric_data_o))
    else $error("fabric word dropped or changed before capture");
  code_sticky_a: assert property (code_err_o |=> code_err_o)
    else $error("code error flag cleared without reset");
  ovf_sticky_a: assert property (overflow_o |=> overflow_o)
    else $error("overflow flag cleared without reset");
  deskew_mode_a: assert property ($past(mode_i) != `MODE_XAUI |-> !deskew_active_o)
    else $error("deskew active outside xaui mode");
  four_lane_a: assert property ($past(reset_n_i) && $past(mode_i) == `MODE_PCIE_X4
    |-> active_lanes_o == 8'h04)
    else $error("four-lane mode reports wrong lane count");
  xaui_rate_a: assert property ($past(reset_n_i) && $past(mode_i) == `MODE_XAUI &&
    $past(byte_deser_en_i) |-> fabric_khz_o == `KHZ_XAUI_FABRIC)
    else $error("xaui fabric rate wrong");
  gen2_rate_a: assert property ($past(reset_n_i) && $past(mode_i) == `MODE_PCIE_X4 &&
    $past(gen2_i) && $past(byte_deser_en_i) |-> fabric_khz_o == `KHZ_GEN2_BD)
    else $error("second generation fabric rate wrong");
  cover property (fabric_valid_o && fabric_ready_i);
  cover property (code_err_o);
  cover property (overflow_o);
endmodule
bind bonded_rx_clock_distribution rx_clock_dist_sva #(.LANES(LANES)) chk_i (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .mode_i(mode_i), .gen2_i(gen2_i),
  .byte_deser_en_i(byte_deser_en_i), .fabric_ready_i(fabric_ready_i),
  .fabric_clk_en_o(fabric_clk_en_o), .fabric_valid_o(fabric_valid_o),
  .fabric_data_o(fabric_data_o), .active_lanes_o(active_lanes_o),
  .deskew_active_o(deskew_active_o), .config_err_o(config_err_o),
  .code_err_o(code_err_o), .overflow_o(overflow_o), .fabric_khz_o(fabric_khz_o));

// *** verif/test_bonded_rx_clock_distribution.sv ***
// Self-checking testbench for the bonded receive clock distribution block.
`timescale 1ns/1ps
`include "rx_bond_consts.vh"
module test_bonded_rx_clock_distribution;
  localparam LANES = 8;
  localparam LS_DIV = 4;
  reg                  clk_sys_i = 1'b0;
  reg                  reset_n_i = 1'b0;
  reg  [2:0]           mode_i = `MODE_PCIE_X4;
  reg                  gen2_i = 1'b0;
  reg                  byte_deser_en_i = 1'b1;
  reg                  hard_core_en_i = 1'b0;
  reg                  slave_block_ok_i = 1'b1;
  reg  [LANES-1:0]     lane_ser_toggle_i = 8'h00;
  reg  [2*LANES-1:0]   lane_ser_bits_i = 16'h0000;
  reg  [1:0]           pace = 2'h0;
  wire                 fabric_ready_i;
  wire                 fabric_clk_en_o;
  wire                 fabric_valid_o;
  wire [16*LANES-1:0]  fabric_data_o;
  wire [7:0]           active_lanes_o;
  wire                 deskew_active_o;
  wire                 config_err_o;
  wire                 code_err_o;
  wire                 overflow_o;
  wire [17:0]          fabric_khz_o;
  wire [15:0]          taken;
  integer              errors = 0;
  integer              checked = 0;
  integer              n;
  initial begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  bonded_rx_clock_distribution #(.LANES(LANES), .LS_DIV(LS_DIV)) bonded_rx_clock_distribution_i (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .mode_i(mode_i), .gen2_i(gen2_i),
    .byte_deser_en_i(byte_deser_en_i), .hard_core_en_i(hard_core_en_i),
    .slave_block_ok_i(slave_block_ok_i), .lane_ser_toggle_i(lane_ser_toggle_i),
    .lane_ser_bits_i(lane_ser_bits_i), .fabric_ready_i(fabric_ready_i),
    .fabric_clk_en_o(fabric_clk_en_o), .fabric_valid_o(fabric_valid_o),
    .fabric_data_o(fabric_data_o), .active_lanes_o(active_lanes_o),
    .deskew_active_o(deskew_active_o), .config_err_o(config_err_o), .code_err_o(code_err_o),
    .overflow_o(overflow_o), .fabric_khz_o(fabric_khz_o));
  fabric_sink fabric_sink_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .fabric_valid_i(fabric_valid_o), .pace_i(pace), .fabric_ready_o(fabric_ready_i),
    .taken_o(taken));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task cfg(input [2:0] m, input g, input b, input h);
    begin
      @(posedge clk_sys_i);
      mode_i <= m;
      gen2_i <= g;
      byte_deser_en_i <= b;
      hard_core_en_i <= h;
      repeat (3) @(posedge clk_sys_i);
      #1;
    end
  endtask
  task mcase(input [2:0] m, input g, input b, input h, input [7:0] ln, input dk, input er,
             input [17:0] khz);
    begin
      cfg(m, g, b, h);
      check(active_lanes_o, ln);
      check(deskew_active_o, dk);
      check(config_err_o, er);
      check(fabric_khz_o, khz);
    end
  endtask
  // Two serial ticks per five cycles would also do; one per two cycles keeps the run short.
  task send(input integer words, input [1:0] b);
    integer k;
    begin
      for (k = 0; k < words * 5; k = k + 1) begin
        @(posedge clk_sys_i);
        lane_ser_bits_i <= {LANES{b}};
        lane_ser_toggle_i <= ~lane_ser_toggle_i;
        @(posedge clk_sys_i);
      end
    end
  endtask
  task gap(input b, input integer exp);
    integer c;
    begin
      cfg(`MODE_PCIE_X4, 1'b0, b, 1'b1);
      c = 0;
      while (fabric_clk_en_o !== 1'b1 && c < 50) begin
        @(posedge clk_sys_i);
        #1;
        c = c + 1;
      end
      c = 0;
      @(posedge clk_sys_i);
      #1;
      while (fabric_clk_en_o !== 1'b1 && c < 50) begin
        @(posedge clk_sys_i);
        #1;
        c = c + 1;
      end
      check(c + 1, exp);
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_modes;
    begin
      mcase(`MODE_PCIE_X4, 1'b0, 1'b1, 1'b0, 8'h04, 1'b0, 1'b0, `KHZ_GEN1_BD);
      mcase(`MODE_XAUI, 1'b0, 1'b1, 1'b0, 8'h04, 1'b1, 1'b0, `KHZ_XAUI_FABRIC);
      mcase(`MODE_GENERIC_X4, 1'b0, 1'b1, 1'b0, 8'h04, 1'b0, 1'b0, `KHZ_UNSPEC);
      mcase(`MODE_PCIE_X4, 1'b1, 1'b1, 1'b0, 8'h04, 1'b0, 1'b0, `KHZ_GEN2_BD);
      mcase(`MODE_PCIE_X4, 1'b0, 1'b0, 1'b1, 8'h04, 1'b0, 1'b0, `KHZ_GEN1_NOBD_HARD);
      mcase(`MODE_PCIE_X8, 1'b0, 1'b1, 1'b0, 8'h08, 1'b0, 1'b0, `KHZ_GEN1_BD);
      mcase(`MODE_GENERIC_X8, 1'b0, 1'b1, 1'b0, 8'h08, 1'b0, 1'b0, `KHZ_UNSPEC);
      mcase(`MODE_PCIE_X4, 1'b1, 1'b0, 1'b0, 8'h04, 1'b0, 1'b1, `KHZ_UNSPEC);
      mcase(`MODE_XAUI, 1'b0, 1'b0, 1'b0, 8'h04, 1'b1, 1'b1, `KHZ_UNSPEC);
      mcase(`MODE_PCIE_X4, 1'b0, 1'b0, 1'b0, 8'h04, 1'b0, 1'b1, `KHZ_UNSPEC);
      mcase(3'h7, 1'b0, 1'b1, 1'b0, 8'h04, 1'b0, 1'b1, `KHZ_UNSPEC);
      @(posedge clk_sys_i);
      slave_block_ok_i <= 1'b0;
      mcase(`MODE_PCIE_X8, 1'b0, 1'b1, 1'b0, 8'h08, 1'b0, 1'b1, `KHZ_UNSPEC);
      mcase(`MODE_GENERIC_X8, 1'b0, 1'b1, 1'b0, 8'h08, 1'b0, 1'b1, `KHZ_UNSPEC);
      @(posedge clk_sys_i);
      slave_block_ok_i <= 1'b1;
    end
  endtask
  task t_flow(input [2:0] m);
    integer c;
    begin
      cfg(m, 1'b0, 1'b1, 1'b0);
      pace <= 2'h1;
      n = taken;
      send(12, 2'h1);
      repeat (60) @(posedge clk_sys_i);
      #1;
      c = 0;
      while (fabric_valid_o !== 1'b1 && c < 20) begin
        @(posedge clk_sys_i);
        #1;
        c = c + 1;
      end
      check(taken != n[15:0], 1'b1);
      check(fabric_valid_o, 1'b1);
      check(fabric_data_o[15:0], 16'h5555);
      check(fabric_data_o[63:48], 16'h5555);
      check(fabric_data_o[16*LANES-1 -: 16], (m == `MODE_PCIE_X8) ? 16'h5555 : 16'h0000);
      check(code_err_o, 1'b0);
      check(overflow_o, 1'b0);
    end
  endtask
  task t_faults;
    begin
      pace <= 2'h2;
      send(12, 2'h3);
      repeat (80) @(posedge clk_sys_i);
      #1;
      check(code_err_o, 1'b1);
      check(overflow_o, 1'b1);
      check(fabric_valid_o, 1'b1);
      @(posedge clk_sys_i);
      reset_n_i <= 1'b0;
      repeat (5) @(posedge clk_sys_i);
      #1;
      check(fabric_valid_o, 1'b0);
      check(overflow_o, 1'b0);
      check(code_err_o, 1'b0);
      check(active_lanes_o, 8'h04);
      @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      pace <= 2'h0;
      repeat (3) @(posedge clk_sys_i);
      #1;
      check(config_err_o, 1'b0);
      check(fabric_khz_o, `KHZ_GEN1_BD);
    end
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    errors = errors + 1;
    give_verdict;
  end
  initial begin
    repeat (5) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    t_modes;
    gap(1'b0, LS_DIV);
    gap(1'b1, 2 * LS_DIV);
    t_flow(`MODE_XAUI);
    t_flow(`MODE_PCIE_X8);
    t_flow(`MODE_PCIE_X4);
    t_faults;
    give_verdict;
  end
endmodule
